// *** logic/vcu_pkg.sv ***
// package of constants for the target-side serial link with hardware flow control
// Notes on behaviour
// - after reset the link runs 115200 baud 8N1 with flow control ignored.
// - baud rate selectable from 9600 to 921600; both ends must match.
// - target sends on its transmit line and receives on its receive line.
// - target asserts receive-ready while it can accept, drops it to hold off.
// - with handshake on, transmitter starts no new character while permit is low.
// - receiver still accepts at least one character after dropping receive-ready.
// - target drives the pass-through enable active to let traffic through.
// - target always actively drives receive-ready so host data is not blocked.
package vcu_pkg;

  // *****************************************************************
  // clock and baud
  // *****************************************************************
  localparam int unsigned CLK_HZ       = 125000000;
  localparam int unsigned OVERSAMPLE   = 16;
  localparam int unsigned BAUD_DEFAULT = 115200;
  localparam int unsigned BAUD_MIN     = 9600;
  localparam int unsigned BAUD_MAX     = 921600;
  localparam int unsigned DIV_W        = 16;
  // tick divider for the oversampled rate, rounded to nearest
  localparam logic [DIV_W-1:0] DIV_DEFAULT =
    DIV_W'((CLK_HZ + (BAUD_DEFAULT * OVERSAMPLE) / 2) / (BAUD_DEFAULT * OVERSAMPLE));
  // fastest divisor rounds up so the rate never exceeds the top of the range
  localparam logic [DIV_W-1:0] DIV_MIN_VAL =
    DIV_W'((CLK_HZ + BAUD_MAX * OVERSAMPLE - 1) / (BAUD_MAX * OVERSAMPLE));
  localparam logic [DIV_W-1:0] DIV_MAX_VAL =
    DIV_W'(CLK_HZ / (BAUD_MIN * OVERSAMPLE));

  // *****************************************************************
  // frame
  // *****************************************************************
  localparam int unsigned DATA_BITS = 8;
  localparam logic [3:0]  OS_LAST   = 4'hf;
  localparam logic [3:0]  OS_MID    = 4'h7;
  localparam logic [2:0]  BIT_LAST  = 3'h7;

  // *****************************************************************
  // fifo
  // *****************************************************************
  localparam int unsigned FIFO_DEPTH = 16;
  // receive-ready drops while this many or fewer slots remain
  localparam logic [4:0]  RX_HEADROOM = 5'h02;

  // *****************************************************************
  // registers, byte addresses
  // *****************************************************************
  localparam logic [11:0] REG_CTRL   = 12'h000;
  localparam logic [11:0] REG_BAUD   = 12'h004;
  localparam logic [11:0] REG_STATUS = 12'h008;
  localparam logic [11:0] REG_TXDATA = 12'h00c;
  localparam logic [11:0] REG_RXDATA = 12'h010;

  // ctrl fields
  localparam int unsigned CTRL_LINK_EN = 0;
  localparam int unsigned CTRL_PERMIT  = 1;
  localparam int unsigned CTRL_RXREADY = 2;
  localparam logic [2:0]  CTRL_RESET   = 3'h0;

  // status fields
  localparam int unsigned ST_TX_FULL   = 0;
  localparam int unsigned ST_TX_EMPTY  = 1;
  localparam int unsigned ST_RX_VALID  = 2;
  localparam int unsigned ST_RX_FULL   = 3;
  localparam int unsigned ST_FRAME_ERR = 4;
  localparam int unsigned ST_OVERRUN   = 5;
  localparam int unsigned ST_TX_BUSY   = 6;
  localparam int unsigned ST_PERMIT    = 7;
  localparam int unsigned ST_RX_READY  = 8;

  typedef enum logic [1:0] {
    TX_IDLE  = 2'b00,
    TX_START = 2'b01,
    TX_DATA  = 2'b10,
    TX_STOP  = 2'b11
  } vcu_tx_state_e;

  typedef enum logic [1:0] {
    RX_IDLE  = 2'b00,
    RX_START = 2'b01,
    RX_DATA  = 2'b10,
    RX_STOP  = 2'b11
  } vcu_rx_state_e;

endpackage

// *** logic/vcu_fifo.sv ***
// synchronous fifo with valid and ready on both sides
`timescale 1ns/100ps
module vcu_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 16
) (
  // clock and reset
  input  wire logic                     clk,
  input  wire logic                     rst,
  // fill side
  input  wire logic                     in_valid,
  output logic                          in_ready,
  input  wire logic [WIDTH-1:0]         in_data,
  // drain side
  output logic                          out_valid,
  input  wire logic                     out_ready,
  output logic [WIDTH-1:0]              out_data,
  // fill level
  output logic [$clog2(DEPTH+1)-1:0]    level
);

  localparam int unsigned AW = $clog2(DEPTH);

  logic [WIDTH-1:0]           mem [DEPTH];
  logic [AW-1:0]              wr_ptr_q;
  logic [AW-1:0]              rd_ptr_q;
  logic [$clog2(DEPTH+1)-1:0] count_q;
  logic                       push;
  logic                       pop;

  assign in_ready  = (count_q != ($clog2(DEPTH+1))'(DEPTH));
  assign out_valid = (count_q != '0);
  assign out_data  = mem[rd_ptr_q];
  assign level     = count_q;
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr_q] <= in_data;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      count_q  <= '0;
    end else begin
      if (push) begin
        wr_ptr_q <= AW'(wr_ptr_q + 1'b1);
      end
      if (pop) begin
        rd_ptr_q <= AW'(rd_ptr_q + 1'b1);
      end
      if (push && !pop) begin
        count_q <= count_q + 1'b1;
      end else if (pop && !push) begin
        count_q <= count_q - 1'b1;
      end
    end
  end

endmodule

// *** logic/vcu_baud.sv ***
// divider producing the oversampled baud tick
`timescale 1ns/100ps
module vcu_baud (
  // clock and reset
  input  wire logic                    clk,
  input  wire logic                    rst,
  // divisor in clock cycles per tick
  input  wire logic [vcu_pkg::DIV_W-1:0] divisor,
  // one-cycle tick
  output logic                         tick
);

  logic [vcu_pkg::DIV_W-1:0] cnt_q;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_q <= '0;
      tick  <= 1'b0;
    end else if (cnt_q >= divisor - 1'b1) begin
      cnt_q <= '0;
      tick  <= 1'b1;
    end else begin
      cnt_q <= cnt_q + 1'b1;
      tick  <= 1'b0;
    end
  end

endmodule

// *** logic/vcu_uart.sv ***
// target-side uart with rts/cts flow control and apb registers
`timescale 1ns/100ps
module vcu_uart (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // serial link pins
  output logic             tx_line,
  input  wire logic        rx_line,
  input  wire logic        tx_permit,
  output logic             rx_ready,
  output logic             link_enable
);

  // *****************************************************************
  // pin synchronisers
  // *****************************************************************
  logic rx_s1_q, rx_s2_q, permit_s1_q, permit_s2_q;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rx_s1_q     <= 1'b1;
      rx_s2_q     <= 1'b1;
      permit_s1_q <= 1'b0;
      permit_s2_q <= 1'b0;
    end else begin
      rx_s1_q     <= rx_line;
      rx_s2_q     <= rx_s1_q;
      permit_s1_q <= tx_permit;
      permit_s2_q <= permit_s1_q;
    end
  end

  // *****************************************************************
  // registers
  // *****************************************************************
  logic [2:0]                ctrl_q;
  logic [vcu_pkg::DIV_W-1:0] div_q;
  logic                      frame_err_q;
  logic                      overrun_q;
  logic                      wr_en;
  logic                      rd_en;
  logic                      addr_ok;
  logic                      set_ferr;
  logic                      set_ovr;

  assign wr_en   = psel && penable && pwrite;
  assign rd_en   = psel && penable && !pwrite;
  assign pready  = 1'b1;
  assign addr_ok = (paddr == vcu_pkg::REG_CTRL) || (paddr == vcu_pkg::REG_BAUD) ||
                   (paddr == vcu_pkg::REG_STATUS) || (paddr == vcu_pkg::REG_TXDATA) ||
                   (paddr == vcu_pkg::REG_RXDATA);
  assign pslverr = psel && penable && !addr_ok;

  // reset leaves handshake ignored and 115200 divisor
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctrl_q <= vcu_pkg::CTRL_RESET;
      div_q  <= vcu_pkg::DIV_DEFAULT;
    end else if (wr_en && paddr == vcu_pkg::REG_CTRL) begin
      ctrl_q <= pwdata[2:0];
    end else if (wr_en && paddr == vcu_pkg::REG_BAUD) begin
      // clamp divisor to the 9600..921600 range
      if (pwdata[vcu_pkg::DIV_W-1:0] < vcu_pkg::DIV_MIN_VAL) begin
        div_q <= vcu_pkg::DIV_MIN_VAL;
      end else if (pwdata[vcu_pkg::DIV_W-1:0] > vcu_pkg::DIV_MAX_VAL) begin
        div_q <= vcu_pkg::DIV_MAX_VAL;
      end else begin
        div_q <= pwdata[vcu_pkg::DIV_W-1:0];
      end
    end
  end

  // sticky error flags, write one to clear; a new event wins
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      frame_err_q <= 1'b0;
      overrun_q   <= 1'b0;
    end else begin
      if (set_ferr) begin
        frame_err_q <= 1'b1;
      end else if (wr_en && paddr == vcu_pkg::REG_STATUS && pwdata[vcu_pkg::ST_FRAME_ERR]) begin
        frame_err_q <= 1'b0;
      end
      if (set_ovr) begin
        overrun_q <= 1'b1;
      end else if (wr_en && paddr == vcu_pkg::REG_STATUS && pwdata[vcu_pkg::ST_OVERRUN]) begin
        overrun_q <= 1'b0;
      end
    end
  end

  // software drives the pass-through enable
  assign link_enable = ctrl_q[vcu_pkg::CTRL_LINK_EN];

  // *****************************************************************
  // baud tick and fifos
  // *****************************************************************
  logic       tick;
  logic       txf_in_ready, txf_valid, txf_pop;
  logic [7:0] txf_data;
  // tx fill level unused: full and empty come from the fifo handshakes
  logic       rxf_in_valid, rxf_in_ready, rxf_valid, rxf_pop;
  logic [7:0] rxf_in_data, rxf_data;
  logic [4:0] rxf_level;

  vcu_baud u_baud (
    .clk     (clk),
    .rst     (rst),
    .divisor (div_q),
    .tick    (tick)
  );

  assign rxf_pop = rd_en && paddr == vcu_pkg::REG_RXDATA;

  vcu_fifo #(.WIDTH(8), .DEPTH(vcu_pkg::FIFO_DEPTH)) u_txf (
    .clk       (clk),
    .rst       (rst),
    .in_valid  (wr_en && paddr == vcu_pkg::REG_TXDATA),
    .in_ready  (txf_in_ready),
    .in_data   (pwdata[7:0]),
    .out_valid (txf_valid),
    .out_ready (txf_pop),
    .out_data  (txf_data),
    .level     ()
  );

  vcu_fifo #(.WIDTH(8), .DEPTH(vcu_pkg::FIFO_DEPTH)) u_rxf (
    .clk       (clk),
    .rst       (rst),
    .in_valid  (rxf_in_valid),
    .in_ready  (rxf_in_ready),
    .in_data   (rxf_in_data),
    .out_valid (rxf_valid),
    .out_ready (rxf_pop),
    .out_data  (rxf_data),
    .level     (rxf_level)
  );

  // ready always driven, drops early leaving headroom for two more
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rx_ready <= 1'b0;
    end else begin
      rx_ready <= !ctrl_q[vcu_pkg::CTRL_RXREADY] ||
                  (5'(vcu_pkg::FIFO_DEPTH) - rxf_level > vcu_pkg::RX_HEADROOM);
    end
  end

  // *****************************************************************
  // transmitter
  // *****************************************************************
  vcu_pkg::vcu_tx_state_e tx_st_q;
  logic [3:0]             tx_os_q;
  logic [2:0]             tx_bit_q;
  logic [7:0]             tx_sh_q;
  logic                   tx_go;

  // no new character starts while permit is low under handshake
  assign tx_go   = txf_valid && link_enable &&
                   (!ctrl_q[vcu_pkg::CTRL_PERMIT] || permit_s2_q);
  assign txf_pop = (tx_st_q == vcu_pkg::TX_IDLE) && tick && tx_go;

  // idle high, start low, lsb first, stop high
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tx_st_q  <= vcu_pkg::TX_IDLE;
      tx_os_q  <= '0;
      tx_bit_q <= '0;
      tx_sh_q  <= '0;
      tx_line  <= 1'b1;
    end else if (tick) begin
      tx_os_q <= tx_os_q + 1'b1;
      unique case (tx_st_q)
        vcu_pkg::TX_IDLE: begin
          tx_line <= 1'b1;
          tx_os_q <= '0;
          if (tx_go) begin
            tx_sh_q <= txf_data;
            tx_line <= 1'b0;
            tx_st_q <= vcu_pkg::TX_START;
          end
        end
        vcu_pkg::TX_START: begin
          if (tx_os_q == vcu_pkg::OS_LAST) begin
            tx_line  <= tx_sh_q[0];
            tx_bit_q <= '0;
            tx_st_q  <= vcu_pkg::TX_DATA;
          end
        end
        vcu_pkg::TX_DATA: begin
          if (tx_os_q == vcu_pkg::OS_LAST) begin
            if (tx_bit_q == vcu_pkg::BIT_LAST) begin
              tx_line <= 1'b1;
              tx_st_q <= vcu_pkg::TX_STOP;
            end else begin
              tx_line  <= tx_sh_q[1];
              tx_sh_q  <= {1'b0, tx_sh_q[7:1]};
              tx_bit_q <= tx_bit_q + 1'b1;
            end
          end
        end
        vcu_pkg::TX_STOP: begin
          if (tx_os_q == vcu_pkg::OS_LAST) begin
            tx_st_q <= vcu_pkg::TX_IDLE;
          end
        end
      endcase
    end
  end

  // *****************************************************************
  // receiver
  // *****************************************************************
  vcu_pkg::vcu_rx_state_e rx_st_q;
  logic [3:0]             rx_os_q;
  logic [2:0]             rx_bit_q;
  logic [7:0]             rx_sh_q;
  logic                   rx_done;

  assign rxf_in_valid = rx_done;
  assign rxf_in_data  = rx_sh_q;
  assign set_ovr      = rx_done && !rxf_in_ready;

  // mid-bit sampling, low stop bit is a framing error
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rx_st_q  <= vcu_pkg::RX_IDLE;
      rx_os_q  <= '0;
      rx_bit_q <= '0;
      rx_sh_q  <= '0;
      rx_done  <= 1'b0;
      set_ferr <= 1'b0;
    end else begin
      rx_done  <= 1'b0;
      set_ferr <= 1'b0;
      if (tick) begin
        rx_os_q <= rx_os_q + 1'b1;
        unique case (rx_st_q)
          vcu_pkg::RX_IDLE: begin
            rx_os_q <= '0;
            if (!rx_s2_q && link_enable) begin
              rx_st_q <= vcu_pkg::RX_START;
            end
          end
          vcu_pkg::RX_START: begin
            if (rx_os_q == vcu_pkg::OS_MID) begin
              rx_os_q  <= '0;
              rx_bit_q <= '0;
              rx_st_q  <= rx_s2_q ? vcu_pkg::RX_IDLE : vcu_pkg::RX_DATA;
            end
          end
          vcu_pkg::RX_DATA: begin
            if (rx_os_q == vcu_pkg::OS_LAST) begin
              rx_sh_q  <= {rx_s2_q, rx_sh_q[7:1]};
              rx_bit_q <= rx_bit_q + 1'b1;
              if (rx_bit_q == vcu_pkg::BIT_LAST) begin
                rx_st_q <= vcu_pkg::RX_STOP;
              end
            end
          end
          vcu_pkg::RX_STOP: begin
            if (rx_os_q == vcu_pkg::OS_LAST) begin
              rx_st_q <= vcu_pkg::RX_IDLE;
              if (rx_s2_q) begin
                rx_done <= 1'b1;
              end else begin
                set_ferr <= 1'b1;
              end
            end
          end
        endcase
      end
    end
  end

  // *****************************************************************
  // read mux
  // *****************************************************************
  always_comb begin
    prdata = 32'h0;
    if (rd_en) begin
      unique case (paddr)
        vcu_pkg::REG_CTRL:   prdata = {29'h0, ctrl_q};
        vcu_pkg::REG_BAUD:   prdata = {16'h0, div_q};
        vcu_pkg::REG_STATUS: prdata = {23'h0, rx_ready, permit_s2_q, tx_st_q != vcu_pkg::TX_IDLE,
                                       overrun_q, frame_err_q, !rxf_in_ready, rxf_valid,
                                       !txf_valid, !txf_in_ready};
        vcu_pkg::REG_RXDATA: prdata = {24'h0, rxf_data};
        default:             prdata = 32'h0;
      endcase
    end
  end

endmodule

// *** test/vcu_uart_asserts.sv ***
// assertion checker for the serial link block
`timescale 1ns/100ps
module vcu_uart_asserts (
  // clock and reset
  input wire logic        clk,
  input wire logic        rst,
  // apb
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // serial link
  input wire logic        tx_line,
  input wire logic        rx_line,
  input wire logic        tx_permit,
  input wire logic        rx_ready,
  input wire logic        link_enable
);
  // *****************************************************************
  // control shadow and properties
  // *****************************************************************
  logic [2:0] ctl_q;
  wire        acc = psel && penable;
  wire        known = paddr inside {vcu_pkg::REG_CTRL, vcu_pkg::REG_BAUD, vcu_pkg::REG_STATUS};
  wire        mapped = known || paddr inside {vcu_pkg::REG_TXDATA, vcu_pkg::REG_RXDATA};

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctl_q <= 3'h0;
    end else if (acc && pwrite && paddr == vcu_pkg::REG_CTRL) begin
      ctl_q <= pwdata[2:0];
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence s_wr_ctrl;
    acc && pwrite && paddr == vcu_pkg::REG_CTRL;
  endsequence
  sequence s_gated_start;
    $fell(tx_line) && ctl_q[1];
  endsequence

  a_unmapped_err: assert property (acc && !mapped |-> pslverr)
    else $error("no error on unmapped access");
  a_mapped_ok: assert property (acc && mapped |-> !pslverr)
    else $error("error on mapped access");
  a_prdata_quiet: assert property (!(acc && !pwrite) |-> prdata == 32'h0)
    else $error("read data outside read access");
  a_link_follow: assert property (s_wr_ctrl |=> link_enable == $past(pwdata[0]))
    else $error("link enable not following control");
  a_no_tx_off: assert property ($fell(tx_line) |-> $past(link_enable))
    else $error("traffic while link disabled");
  a_permit_gate: assert property (s_gated_start |-> $past(tx_permit, 2) || $past(tx_permit, 3))
    else $error("frame started without permit");
  a_ready_free: assert property (!ctl_q[2] && !$past(ctl_q[2]) && !$past(rst) |-> rx_ready)
    else $error("receive ready low with flow control off");
  a_bit_hold: assert property ($changed(tx_line) |=> $stable(tx_line) [*7])
    else $error("serial bit shorter than minimum");
endmodule

// *** test/vcu_host_model.sv ***
// behavioural board controller at the far end of the serial link
`timescale 1ns/100ps
module vcu_host_model #(
  parameter int BIT = 128
) (
  // clock
  input wire logic       clk,
  // serial link
  input wire logic       tx_line,
  input wire logic       rx_ready,
  output logic           rx_line,
  output logic           tx_permit,
  // handshake mode and buffer state
  input wire logic [1:0] mode,
  input wire logic       buf_full
);
  // *****************************************************************
  // permit, sender and receiver
  // *****************************************************************
  logic [7:0] got[$];
  logic [7:0] rb;
  int         ferr = 0;
  int         ri;

  initial begin
    rx_line = 1'b1;
    tx_permit = 1'b1;
  end

  // undriven permit toggles every cycle
  always @(posedge clk) tx_permit <= mode[0] ? !buf_full : !tx_permit;

  task automatic send(input logic [7:0] b, input logic stop);
    logic [9:0] f;
    f = {stop, b, 1'b0};
    if (mode[1]) while (rx_ready !== 1'b1) @(posedge clk);
    for (int i = 0; i < 10; i++) begin
      @(posedge clk) rx_line <= f[i];
      repeat (BIT - 1) @(posedge clk);
    end
    @(posedge clk) rx_line <= 1'b1;
  endtask

  always begin
    @(negedge tx_line);
    repeat (BIT / 2) @(posedge clk);
    for (ri = 0; ri < 8; ri++) begin
      repeat (BIT) @(posedge clk);
      rb[ri] = tx_line;
    end
    repeat (BIT) @(posedge clk);
    if (tx_line) got.push_back(rb);
    else ferr++;
  end
endmodule

// *** test/vcu_uart_tb.sv ***
// self-checking bench for the serial link block
`timescale 1ns/100ps
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin miscompares++; \
  $display("[ERR] %0t got %h exp %h", $time, (a), (b)); end end
module vcu_uart_tb;
  localparam int BIT = vcu_pkg::OVERSAMPLE * vcu_pkg::DIV_MIN_VAL;
  localparam int FRM = 10 * BIT;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        tx_line;
  logic        rx_line;
  logic        tx_permit;
  logic        rx_ready;
  logic        link_enable;
  logic [1:0]  mode = 2'h0;
  logic        buf_full = 1'b0;
  logic [31:0] r;
  logic        e;
  int          miscompares = 0;
  int          n_tests = 0;
  int          i;
  int          k;

  always #4 clk = ~clk;

  vcu_uart dut_u (.clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .tx_line(tx_line),
    .rx_line(rx_line), .tx_permit(tx_permit), .rx_ready(rx_ready), .link_enable(link_enable));
  vcu_host_model #(.BIT(BIT)) host_u (.clk(clk), .tx_line(tx_line), .rx_ready(rx_ready), .rx_line(rx_line),
    .tx_permit(tx_permit), .mode(mode), .buf_full(buf_full));

  // *****************************************************************
  // bus tasks and closing
  // *****************************************************************
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rd(input logic [11:0] a);
    apb(1'b0, a, 32'h0);
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge clk);
  endtask
  task end_of_test;
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  initial begin
    idle(90000);
    miscompares++;
    end_of_test();
  end

  initial begin
    idle(5);
    rst <= 1'b0;
    @(negedge clk);
    `CHK(link_enable, 1'b0)
    `CHK(tx_line, 1'b1)
    rd(vcu_pkg::REG_CTRL);
    `CHK(r, 32'h0)
    rd(vcu_pkg::REG_BAUD);
    `CHK(r, 32'(vcu_pkg::DIV_DEFAULT))
    rd(vcu_pkg::REG_STATUS);
    `CHK(r & 32'hff7f, 32'h0000_0102)
    apb(1'b0, 12'h014, 32'h0);
    `CHK(e, 1'b1)
    wr(vcu_pkg::REG_BAUD, 32'h0);
    rd(vcu_pkg::REG_BAUD);
    `CHK(r, 32'(vcu_pkg::DIV_MIN_VAL))
    wr(vcu_pkg::REG_BAUD, 32'hffff);
    rd(vcu_pkg::REG_BAUD);
    `CHK(r, 32'(vcu_pkg::DIV_MAX_VAL))
    wr(vcu_pkg::REG_BAUD, 32'(vcu_pkg::DIV_MIN_VAL));
    // fill the transmit fifo, hold it by enable, then by permit
    mode <= 2'h1;
    buf_full <= 1'b1;
    for (i = 0; i < 17; i++) wr(vcu_pkg::REG_TXDATA, 32'h30 + i);
    rd(vcu_pkg::REG_STATUS);
    `CHK(r[0], 1'b1)
    wr(vcu_pkg::REG_CTRL, 32'h2);
    idle(3 * FRM);
    `CHK(host_u.got.size(), 0)
    wr(vcu_pkg::REG_CTRL, 32'h3);
    idle(3 * FRM);
    `CHK(host_u.got.size(), 0)
    rd(vcu_pkg::REG_STATUS);
    `CHK(r[8:6], 3'h4)
    buf_full <= 1'b0;
    for (k = 0; k < 20 * FRM && host_u.got.size() < 16; k++) @(posedge clk);
    for (i = 0; i < 16; i++) `CHK(host_u.got[i], 8'(8'h30 + i))
    `CHK(host_u.ferr, 0)
    rd(vcu_pkg::REG_STATUS);
    `CHK(r[1], 1'b1)
    // receive a good byte, then one with a low stop bit
    mode <= 2'h2;
    wr(vcu_pkg::REG_CTRL, 32'h1);
    host_u.send(8'h5a, 1'b1);
    idle(BIT);
    rd(vcu_pkg::REG_STATUS);
    `CHK(r[2], 1'b1)
    rd(vcu_pkg::REG_RXDATA);
    `CHK(r[7:0], 8'h5a)
    mode <= 2'h0;
    host_u.send(8'hc3, 1'b0);
    idle(BIT);
    rd(vcu_pkg::REG_STATUS);
    `CHK(r[4], 1'b1)
    `CHK(r[2], 1'b0)
    wr(vcu_pkg::REG_STATUS, 32'h10);
    rd(vcu_pkg::REG_STATUS);
    `CHK(r[4], 1'b0)
    // receive flow control: sender stalls on ready, nothing is lost
    mode <= 2'h3;
    wr(vcu_pkg::REG_CTRL, 32'h5);
    fork
      for (int j = 0; j < 16; j++) host_u.send(8'(8'h40 + j), 1'b1);
    join_none
    for (k = 0; k < 20 * FRM && rx_ready !== 1'b0; k++) @(posedge clk);
    idle(2 * FRM);
    `CHK(rx_ready, 1'b0)
    rd(vcu_pkg::REG_STATUS);
    `CHK(r[5], 1'b0)
    for (i = 0; i < 16; i++) begin
      rd(vcu_pkg::REG_STATUS);
      for (k = 0; k < 1000 && r[2] !== 1'b1; k++) rd(vcu_pkg::REG_STATUS);
      rd(vcu_pkg::REG_RXDATA);
      `CHK(r[7:0], 8'(8'h40 + i))
    end
    rd(vcu_pkg::REG_STATUS);
    `CHK(r[5], 1'b0)
    idle(4);
    `CHK(rx_ready, 1'b1)
    `CHK(host_u.got.size(), 16)
    end_of_test();
  end
endmodule

bind vcu_uart vcu_uart_asserts chk_u (.clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .tx_line(tx_line),
  .rx_line(rx_line), .tx_permit(tx_permit), .rx_ready(rx_ready), .link_enable(link_enable));
